// ### ctd_pkg.sv
// constants, register map and field layout of the cable diagnostics unit
package ctd_pkg;
  // ---------------------------------------------------------------------
  // register map (index times four is the byte address)
  // ---------------------------------------------------------------------
  localparam logic [7:0] CTD_IDX_CTRL = 8'h1e;
  localparam logic [7:0] CTD_IDX_RES = 8'h1f;
  localparam logic [7:0] CTD_IDX_IRQ_STAT = 8'h20;
  localparam logic [7:0] CTD_IDX_IRQ_CLR = 8'h21;
  localparam logic [7:0] CTD_IDX_IRQ_EN = 8'h22;
  localparam int CTD_ADDR_W = 10;
  // ---------------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------------
  localparam int CTD_REQ_HI = 15;
  localparam int CTD_REQ_LO = 14;
  localparam int CTD_DRV_LO = 12;
  localparam int CTD_LSN_LO = 10;
  localparam int CTD_RNG_LO = 2;
  localparam logic [1:0] CTD_REQ_AUTO = 2'h3;
  localparam logic [1:0] CTD_REQ_SINGLE = 2'h2;
  // ---------------------------------------------------------------------
  // result register fields and codes
  // ---------------------------------------------------------------------
  localparam int CTD_KIND_A_LO = 14;
  localparam int CTD_SHORT_LO = 2;
  localparam logic [1:0] CTD_KIND_SHORT = 2'h3;
  localparam logic [1:0] CTD_KIND_OPEN = 2'h2;
  localparam logic [1:0] CTD_KIND_MISMATCH = 2'h1;
  localparam logic [1:0] CTD_KIND_GOOD = 2'h0;
  localparam logic [7:0] CTD_RANGE_NONE = 8'hff;
  localparam logic [7:0] CTD_RANGE_MAX = 8'hfe;
  localparam logic [7:0] CTD_RANGE_ZERO = 8'h08;
  localparam logic [15:0] CTD_REG_RESET = 16'h0000;
  // ---------------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------------
  localparam logic [3:0] CTD_STEP_LAST = 4'h9;
  localparam logic [3:0] CTD_STEP_FIRST_PAIR = 4'h6;
  localparam int CTD_IRQ_W = 2;
  localparam int CTD_IRQ_DONE = 0;
  localparam int CTD_IRQ_SHORT = 1;
  typedef enum logic [1:0] {
    CTD_IDLE = 2'b00,
    CTD_ISSUE = 2'b01,
    CTD_WAIT = 2'b10
  } ctd_state_t;
endpackage : ctd_pkg

// ### ctd_top.sv
// cable reflectometry sequencer with its apb register file
//
// Overview of operation
// - request field shows running, done valid, invalid
// - request 11 runs all ten combinations
// - request 10 runs the selected combination
// - bit 15 self clears; bit 14 valid
// - drive select 00..11 picks pair a..d
// - listen select same encoding as drive
// - automatic run ignores both pair selects
// - distance: chosen pair, or last fault
// - shorts cd..ab first, then pairs d..a
// - no fault gives distance all ones
// - distance code linear, 08 zero, fe 200m
// - per pair kind: short, open, mismatch, good
// - one flag per inter-pair short, bits 7..2
// - single run reports kind in pair a field
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module ctd_top
  import ctd_pkg::*;
(
  input wire logic i_clk, // core clock, 20 MHz
  input wire logic i_reset, // async reset, active high
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb access phase
  input wire logic i_pwrite, // apb write
  input wire logic [ctd_pkg::CTD_ADDR_W-1:0] i_paddr, // apb byte address
  input wire logic [31:0] i_pwdata, // apb write data
  output logic o_pready, // apb ready
  output logic [31:0] o_prdata, // apb read data
  output logic o_pslverr, // apb error on unmapped address
  output logic o_probe_start, // one-cycle pulse, launch one reflection
  output logic [1:0] o_probe_drive, // driving pair of the launch
  output logic [1:0] o_probe_listen, // listening pair of the launch
  input wire logic i_probe_done, // one-cycle pulse, measurement finished
  input wire logic [1:0] i_probe_kind, // fault kind found
  input wire logic [7:0] i_probe_range, // distance code of the fault
  input wire logic i_probe_valid, // measurement trustworthy
  output logic o_irq // level interrupt
);
  import ctd_pkg::*;

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  // driving pair of an automatic step: shorts c-d..a-b, then d,c,b,a
  // steps 0..5 probe the inter-pair shorts, steps 6..9 the single pairs
  // step 9 falls to the default arm, pair a driving and listening
  function automatic logic [1:0] step_drive(input logic [3:0] s);
    case (s)
      4'h0: step_drive = 2'h2;
      4'h1: step_drive = 2'h1;
      4'h2: step_drive = 2'h1;
      4'h3: step_drive = 2'h0;
      4'h4: step_drive = 2'h0;
      4'h5: step_drive = 2'h0;
      4'h6: step_drive = 2'h3;
      4'h7: step_drive = 2'h2;
      4'h8: step_drive = 2'h1;
      default: step_drive = 2'h0;
    endcase
  endfunction : step_drive

  // listening pair of an automatic step, same step numbering
  function automatic logic [1:0] step_listen(input logic [3:0] s);
    case (s)
      4'h0: step_listen = 2'h3;
      4'h1: step_listen = 2'h3;
      4'h2: step_listen = 2'h2;
      4'h3: step_listen = 2'h3;
      4'h4: step_listen = 2'h2;
      4'h5: step_listen = 2'h1;
      4'h6: step_listen = 2'h3;
      4'h7: step_listen = 2'h2;
      4'h8: step_listen = 2'h1;
      default: step_listen = 2'h0;
    endcase
  endfunction : step_listen

  // all ones is kept for no fault, so a measured fault never reports it
  // trade-off: a fault at the very end of the range reads one code short
  function automatic logic [7:0] clip_range(input logic [7:0] r);
    clip_range = (r == CTD_RANGE_NONE) ? CTD_RANGE_MAX : r;
  endfunction : clip_range

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  ctd_state_t state_q;
  // run type is latched at start, so later writes cannot change it
  logic auto_q;
  logic valid_q;
  logic [3:0] step_q;
  logic [1:0] drv_sel_q;
  logic [1:0] lsn_sel_q;
  logic [7:0] range_q;
  // kind_q index follows the pair code: 0 is pair a, 3 is pair d
  logic [1:0] kind_q [4];
  // short_q[0] is c-d and short_q[5] is a-b, matching the step order
  logic [5:0] short_q;
  logic [CTD_IRQ_W-1:0] irq_stat_q;
  logic [CTD_IRQ_W-1:0] irq_en_q;
  logic run_end;
  logic [CTD_IRQ_W-1:0] irq_set;

  // apb decode
  logic bus_acc;
  logic bus_wr;
  logic [7:0] bus_idx;
  logic mapped;
  logic busy;
  logic wr_ctrl;
  logic wr_res;
  logic start_auto;
  logic start_single;
  logic [15:0] ctrl_view;
  logic [15:0] res_view;

  // the access completes in its second cycle, when pready comes back high
  assign bus_acc = i_psel & i_penable & ~o_pready;
  assign bus_wr = bus_acc & i_pwrite;
  // index drops the two byte-lane bits, so unaligned low bits are ignored
  assign bus_idx = i_paddr[CTD_ADDR_W-1:2];
  assign mapped = (bus_idx >= CTD_IDX_CTRL) && (bus_idx <= CTD_IDX_IRQ_EN);
  assign busy = (state_q != CTD_IDLE);
  assign wr_ctrl = bus_wr && (bus_idx == CTD_IDX_CTRL);
  assign wr_res = bus_wr && (bus_idx == CTD_IDX_RES) && !busy;
  // a new request while a run is going is ignored
  assign start_auto = wr_ctrl && !busy &&
                      (i_pwdata[CTD_REQ_HI:CTD_REQ_LO] == CTD_REQ_AUTO);
  assign start_single = wr_ctrl && !busy &&
                        (i_pwdata[CTD_REQ_HI:CTD_REQ_LO] == CTD_REQ_SINGLE);
  // a single run ends on its only answer, an automatic one on step nine
  assign run_end = (state_q == CTD_WAIT) && i_probe_done &&
                   (!auto_q || step_q == CTD_STEP_LAST);

  // register views; reserved low bits read as zero
  assign ctrl_view = {busy, busy ? auto_q : valid_q, drv_sel_q, lsn_sel_q, range_q,
                      2'b00};
  assign res_view = {kind_q[0], kind_q[1], kind_q[2], kind_q[3], short_q, 2'b00};

  // ---------------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------------
  // one launch per step; the next launch waits for the previous answer
  // limitation: a front end that never answers keeps the unit busy until reset
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= CTD_IDLE;
      auto_q <= 1'b0;
      step_q <= 4'h0;
    end else begin
      case (state_q)
        CTD_IDLE: begin
          if (start_auto || start_single) begin
            state_q <= CTD_ISSUE;
            auto_q <= start_auto;
            step_q <= 4'h0;
          end
        end
        CTD_ISSUE: begin
          state_q <= CTD_WAIT;
        end
        CTD_WAIT: begin
          if (i_probe_done) begin
            if (run_end) begin
              state_q <= CTD_IDLE;
            end else begin
              state_q <= CTD_ISSUE;
              step_q <= step_q + 4'h1;
            end
          end
        end
        default: begin
          state_q <= CTD_IDLE;
        end
      endcase
    end
  end

  // launch pulse and pair choice toward the analogue front end
  // the pair outputs hold between launches so the front end may sample late
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_probe_start <= 1'b0;
      o_probe_drive <= 2'h0;
      o_probe_listen <= 2'h0;
    end else begin
      o_probe_start <= (state_q == CTD_ISSUE);
      if (state_q == CTD_ISSUE) begin
        if (auto_q) begin
          o_probe_drive <= step_drive(step_q);
          o_probe_listen <= step_listen(step_q);
        end else begin
          o_probe_drive <= drv_sel_q;
          o_probe_listen <= lsn_sel_q;
        end
      end
    end
  end

  // validity: every measurement of the run must be trustworthy
  // one untrustworthy answer marks the run invalid until the next start
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      valid_q <= 1'b0;
    end else if (start_auto || start_single) begin
      valid_q <= 1'b1;
    end else if (state_q == CTD_WAIT && i_probe_done && !i_probe_valid) begin
      valid_q <= 1'b0;
    end
  end

  // pair selects, written by software only while idle
  // writes during a run are dropped, so a launch pair never moves mid-run
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      drv_sel_q <= 2'h0;
      lsn_sel_q <= 2'h0;
    end else if (wr_ctrl && !busy) begin
      drv_sel_q <= i_pwdata[CTD_DRV_LO+1:CTD_DRV_LO];
      lsn_sel_q <= i_pwdata[CTD_LSN_LO+1:CTD_LSN_LO];
    end
  end

  // distance: preset to no fault, overwritten by each later fault
  // software may preload it while idle; a start always overwrites it
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      range_q <= 8'h00;
    end else if (start_auto || start_single) begin
      range_q <= CTD_RANGE_NONE;
    end else if (wr_ctrl && !busy) begin
      range_q <= i_pwdata[CTD_RNG_LO+7:CTD_RNG_LO];
    end else if (state_q == CTD_WAIT && i_probe_done && i_probe_kind != CTD_KIND_GOOD) begin
      // code passes through linearly; 08 and below mean zero metres
      range_q <= clip_range(i_probe_range);
    end
  end

  // per pair fault kinds and inter-pair short flags
  // a single run reports only through the pair a field
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int p = 0; p < 4; p++) begin
        kind_q[p] <= CTD_KIND_GOOD;
      end
      short_q <= 6'h00;
    end else if (start_auto || start_single) begin
      for (int p = 0; p < 4; p++) begin
        kind_q[p] <= CTD_KIND_GOOD;
      end
      short_q <= 6'h00;
    end else if (wr_res) begin
      kind_q[0] <= i_pwdata[CTD_KIND_A_LO+1:CTD_KIND_A_LO];
      kind_q[1] <= i_pwdata[CTD_KIND_A_LO-1:CTD_KIND_A_LO-2];
      kind_q[2] <= i_pwdata[CTD_KIND_A_LO-3:CTD_KIND_A_LO-4];
      kind_q[3] <= i_pwdata[CTD_KIND_A_LO-5:CTD_KIND_A_LO-6];
      short_q <= i_pwdata[CTD_SHORT_LO+5:CTD_SHORT_LO];
    end else if (state_q == CTD_WAIT && i_probe_done) begin
      if (!auto_q) begin
        kind_q[0] <= i_probe_kind;
      end else if (step_q >= CTD_STEP_FIRST_PAIR) begin
        kind_q[step_drive(step_q)] <= i_probe_kind;
      end else if (i_probe_kind == CTD_KIND_SHORT) begin
        // step 0 is c-d at bit 2, step 5 is a-b at bit 7
        short_q[step_q[2:0]] <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------------
  // bit 0 marks a finished run, bit 1 a short seen between two pairs in an automatic run
  assign irq_set[CTD_IRQ_DONE] = run_end;
  assign irq_set[CTD_IRQ_SHORT] = (state_q == CTD_WAIT) && i_probe_done && auto_q &&
                                  (step_q < CTD_STEP_FIRST_PAIR) &&
                                  (i_probe_kind == CTD_KIND_SHORT);

  // sticky status; a set in the clearing cycle wins
  // writing ones clears a bit; writing zeros leaves it alone
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      irq_stat_q <= '0;
    end else if (bus_wr && bus_idx == CTD_IDX_IRQ_CLR) begin
      irq_stat_q <= (irq_stat_q & ~i_pwdata[CTD_IRQ_W-1:0]) | irq_set;
    end else begin
      irq_stat_q <= irq_stat_q | irq_set;
    end
  end

  // enable mask, same layout as the status bits
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      irq_en_q <= '0;
    end else if (bus_wr && bus_idx == CTD_IDX_IRQ_EN) begin
      irq_en_q <= i_pwdata[CTD_IRQ_W-1:0];
    end
  end

  // registered, so the line lags the status bit by one cycle
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_stat_q & irq_en_q);
    end
  end

  // ---------------------------------------------------------------------
  // apb answer
  // ---------------------------------------------------------------------
  // one wait state keeps read data and ready straight from flip-flops
  // writes land in the first access cycle, one edge before ready is seen
  // read data is zero outside the answer cycle, so a stale word never leaks
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else begin
      o_pready <= bus_acc;
      o_pslverr <= bus_acc && !mapped;
      o_prdata <= 32'h0000_0000;
      if (bus_acc && !i_pwrite) begin
        case (bus_idx)
          CTD_IDX_CTRL: o_prdata <= {16'h0000, ctrl_view};
          CTD_IDX_RES: o_prdata <= {16'h0000, res_view};
          CTD_IDX_IRQ_STAT: o_prdata <= {30'h0000_0000, irq_stat_q};
          CTD_IDX_IRQ_EN: o_prdata <= {30'h0000_0000, irq_en_q};
          default: o_prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule : ctd_top
`default_nettype wire

// ### ctd_checker.sv
// port assertions for the cable diagnostics unit
`timescale 1ns/10ps
`default_nettype none
module ctd_checker
  import ctd_pkg::*;
(
  input wire logic i_clk, // core clock
  input wire logic i_reset, // async reset
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb access
  input wire logic i_pwrite, // apb write
  input wire logic [ctd_pkg::CTD_ADDR_W-1:0] i_paddr, // apb address
  input wire logic [31:0] i_pwdata, // apb write data
  input wire logic o_pready, // apb ready
  input wire logic [31:0] o_prdata, // apb read data
  input wire logic o_pslverr, // apb error
  input wire logic o_probe_start, // launch pulse
  input wire logic [1:0] o_probe_drive, // driving pair
  input wire logic [1:0] o_probe_listen, // listening pair
  input wire logic i_probe_done, // measurement done
  input wire logic [1:0] i_probe_kind, // fault kind
  input wire logic [7:0] i_probe_range, // distance code
  input wire logic i_probe_valid, // measurement good
  input wire logic o_irq // interrupt
);
  // ---------------------------------------------------------------------
  // automatic launch order, drive then listen pair
  // ---------------------------------------------------------------------
  localparam logic [3:0] SEQ [10] = '{4'hb, 4'h7, 4'h6, 4'h3, 4'h2, 4'h1, 4'hf, 4'ha, 4'h5, 4'h0};
  logic [3:0] prev_q;
  logic [4:0] nxt;
  // previous launch pair; held between pulses so last cycle's value is it
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      prev_q <= 4'h0;
    end else begin
      prev_q <= {o_probe_drive, o_probe_listen};
    end
  end
  // successor lookup; the last pair has none, so a new run is never judged
  always_comb begin
    nxt = 5'h00;
    for (int i = 0; i < 9; i++) begin
      if (SEQ[i] == prev_q) begin
        nxt = {1'b1, SEQ[i+1]};
      end
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  AST_ONE_WAIT: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("apb answer not after one wait state");
  AST_READY_STANDS: assert property (o_pready |=> !o_pready)
    else $error("apb ready held too long");
  AST_ERR_UNMAPPED: assert property (o_pready |-> o_pslverr ==
    (i_paddr[9:2] < CTD_IDX_CTRL || i_paddr[9:2] > CTD_IDX_IRQ_EN))
    else $error("apb error flag wrong for address");
  // bits 1:0 are reserved only in the control and result registers; the irq registers use them
  AST_RESERVED_ZERO: assert property (o_pready |-> o_prdata[31:16] == 16'h0000
    && (i_paddr[9:2] > CTD_IDX_RES || o_prdata[1:0] == 2'b00))
    else $error("reserved read bits not zero");
  AST_RDATA_IDLE: assert property (!o_pready |-> o_prdata == 32'h0000_0000)
    else $error("read data outside answer");
  AST_START_PULSE: assert property (o_probe_start |=> !o_probe_start)
    else $error("launch pulse longer than one cycle");
  AST_SEL_HOLD: assert property (!o_probe_start |-> $stable(o_probe_drive)
    && $stable(o_probe_listen))
    else $error("launch pair moved between launches");
  AST_AUTO_ORDER: assert property (o_probe_start && $past(i_probe_done, 2)
    && nxt[4] |-> {o_probe_drive, o_probe_listen} == nxt[3:0])
    else $error("automatic launch out of order");
endmodule : ctd_checker
bind ctd_top ctd_checker ctd_checker_inst (.i_clk(i_clk), .i_reset(i_reset), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
  .o_probe_start(o_probe_start), .o_probe_drive(o_probe_drive),
  .o_probe_listen(o_probe_listen), .i_probe_done(i_probe_done), .i_probe_kind(i_probe_kind),
  .i_probe_range(i_probe_range), .i_probe_valid(i_probe_valid), .o_irq(o_irq));
`default_nettype wire

// ### tb.sv
// self-checking bench for the cable diagnostics unit
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ctd_pkg::*;
  logic i_clk = 0, i_reset = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [CTD_ADDR_W-1:0] i_paddr = '0;
  logic [31:0] i_pwdata = '0, o_prdata;
  logic o_pready, o_pslverr, o_probe_start, o_irq;
  logic [1:0] o_probe_drive, o_probe_listen, i_probe_kind = 2'h0;
  logic [7:0] i_probe_range = 8'h00;
  logic i_probe_done = 0, i_probe_valid = 0;
  int mismatches = 0, n_compared = 0, cyc = 0;
  ctd_top ctd_top_inst (.i_clk(i_clk), .i_reset(i_reset), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
    .o_probe_start(o_probe_start), .o_probe_drive(o_probe_drive),
    .o_probe_listen(o_probe_listen), .i_probe_done(i_probe_done), .i_probe_kind(i_probe_kind),
    .i_probe_range(i_probe_range), .i_probe_valid(i_probe_valid), .o_irq(o_irq));
  // 50 ns period
  always #25 i_clk = ~i_clk;
  // ---------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  // a hang ends in the verdict instead of running on
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one apb transfer; request held until ready is sampled high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    @(posedge i_clk);
    i_psel <= 1;
    i_penable <= 0;
    i_pwrite <= wr;
    i_paddr <= {idx, 2'b00};
    i_pwdata <= wd;
    @(posedge i_clk);
    i_penable <= 1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 0;
    i_penable <= 0;
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] rd;
    logic err;
    apb(1, idx, wd, rd, err);
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic err;
    apb(0, idx, 32'h0000_0000, d, err);
    chk(nm, exp, d);
  endtask : rd
  // front end: answer one launch the cycle after it is seen
  task automatic probe(input logic [1:0] kind, input logic [7:0] rng, input logic ok,
    output logic [3:0] pl);
    do @(posedge i_clk); while (o_probe_start !== 1'b1);
    pl = {o_probe_drive, o_probe_listen};
    i_probe_done <= 1;
    i_probe_kind <= kind;
    i_probe_range <= rng;
    i_probe_valid <= ok;
    @(posedge i_clk);
    i_probe_done <= 0;
  endtask : probe
  // ---------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    logic err;
    rd("ctrl", CTD_IDX_CTRL, 32'h0000_0000);
    rd("result", CTD_IDX_RES, 32'h0000_0000);
    rd("irq en", CTD_IDX_IRQ_EN, 32'h0000_0000);
    apb(0, 8'h23, 32'h0000_0000, d, err);
    chk("unmapped err", 32'h0000_0001, {31'h0, err});
    $display("test reset done");
  endtask : t_reset
  // every select code and fault kind; good termination keeps all ones
  task automatic t_single();
    logic [7:0] rng [4] = '{8'h55, 8'h08, 8'hfe, 8'h80};
    logic [1:0] s;
    logic [3:0] pl;
    for (int k = 0; k < 4; k++) begin
      s = k[1:0];
      wr(CTD_IDX_CTRL, {16'h0000, CTD_REQ_SINGLE, s, ~s, 10'h000});
      probe(s, rng[k], k != 0, pl);
      chk("pair", {28'h0, s, ~s}, {28'h0, pl});
      rd("ctrl", CTD_IDX_CTRL, {16'h0000, (k != 0) ? 2'b01 : 2'b00, s, ~s,
        (k == 0) ? CTD_RANGE_NONE : rng[k], 2'b00});
      rd("result", CTD_IDX_RES, {16'h0000, s, 14'h0000});
    end
    $display("test single done");
  endtask : t_single
  // all ten launches in order, selects ignored, last fault distance kept
  task automatic t_auto();
    logic [3:0] order [10] = '{4'hb, 4'h7, 4'h6, 4'h3, 4'h2, 4'h1, 4'hf, 4'ha, 4'h5, 4'h0};
    logic [1:0] kind [10] = '{2'h3, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h0, 2'h1, 2'h0};
    logic [7:0] rng [10] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h20, 8'h21,
      8'h30, 8'h31};
    logic [3:0] pl;
    logic [31:0] d;
    logic err;
    wr(CTD_IDX_IRQ_EN, 32'h0000_0003);
    wr(CTD_IDX_CTRL, 32'h0000_fc00);
    fork
      for (int i = 0; i < 10; i++) begin
        probe(kind[i], rng[i], 1, pl);
        chk("auto pair", {28'h0, order[i]}, {28'h0, pl});
      end
      begin
        apb(0, CTD_IDX_CTRL, 32'h0000_0000, d, err);
        chk("busy req", 32'h0000_0003, {30'h0, d[15:14]});
      end
    join
    rd("ctrl", CTD_IDX_CTRL, 32'h0000_7cc0);
    rd("result", CTD_IDX_RES, 32'h0000_1204);
    $display("test auto done");
  endtask : t_auto
  // raise, clear one bit, mask, clear the rest
  task automatic t_irq();
    rd("irq stat", CTD_IDX_IRQ_STAT, 32'h0000_0003);
    chk("irq", 32'h0000_0001, {31'h0, o_irq});
    wr(CTD_IDX_IRQ_CLR, 32'h0000_0001);
    rd("irq stat", CTD_IDX_IRQ_STAT, 32'h0000_0002);
    wr(CTD_IDX_IRQ_EN, 32'h0000_0001);
    @(posedge i_clk);
    chk("irq masked", 32'h0000_0000, {31'h0, o_irq});
    wr(CTD_IDX_IRQ_CLR, 32'h0000_0002);
    rd("irq stat", CTD_IDX_IRQ_STAT, 32'h0000_0000);
    $display("test irq done");
  endtask : t_irq
  // reset for 16 cycles, then the scenarios
  initial begin
    repeat (16) @(posedge i_clk);
    i_reset <= 0;
    t_reset();
    t_single();
    t_auto();
    t_irq();
    give_verdict();
  end
endmodule : tb
`default_nettype wire
